/* design/sicd_defines.svh */
// constants for the servo init command decoder
// assumes a 50 MHz sys_clk and 16-bit command words
`ifndef SICD_DEFINES_SVH
`define SICD_DEFINES_SVH
`define SICD_OP_GAIN     8'h46
`define SICD_OP_IDLE_OFF 8'hab
`define SICD_OP_IDLE_HI  8'hfb
`define SICD_OP_IDLE_LO  8'hbb
`define SICD_OP_FILTER   8'hfc
`define SICD_OP_DIR      8'hb8
`define SICD_OP_DUAL     8'hf3
`define SICD_LEN_GAIN    4'h9
`define SICD_LEN_FILTER  4'h3
`define SICD_LEN_DIR     4'h2
`define SICD_GAIN_MAX    15'h7fff
`define SICD_FILT_RST    15'h0053
`define SICD_TICK_US     120
`define SICD_CLK_MHZ     50
`define SICD_TICK_CYC    (`SICD_TICK_US * `SICD_CLK_MHZ)
`define SICD_A_STATUS    12'h000
`define SICD_A_MASK      12'h004
`define SICD_A_MODE      12'h008
`define SICD_A_INPUTS    12'h00c
`define SICD_A_GAIN0     12'h020
`define SICD_A_FILT0     12'h040
`define SICD_EV_ACK      0
`define SICD_EV_SEQ      1
`define SICD_EV_INCHG    2
`define SICD_EV_BADOP    3
`endif

/* design/sicd_pkg.sv */
// types shared by the servo init command decoder
// assumes sicd_defines.svh for numeric constants
package sicd_pkg;
  typedef enum logic {SICD_OPCODE, SICD_ARGS} sicd_state_e;
  typedef logic [14:0] sicd_gain_t;
  typedef logic [3:0]  sicd_evt_t;
endpackage

/* design/sicd_top.sv */
// servo init command decoder with apb status/config window
// assumes command words synchronous to sys_clk, one word per valid
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "sicd_defines.svh"
module sicd_top #(
  parameter int LINES    = 7,
  parameter int TICK_CYC = `SICD_TICK_CYC
) (
  // clock and reset
  input  wire  logic                 sys_clk,
  input  wire  logic                 arst_n,
  // apb slave
  input  wire  logic                 psel,
  input  wire  logic                 penable,
  input  wire  logic                 pwrite,
  input  wire  logic [11:0]          paddr,
  input  wire  logic [31:0]          pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  output logic                       irq,
  // command word channel
  input  wire  logic                 cw_valid,
  input  wire  logic [15:0]          cw_data,
  output logic                       cmd_ack,
  // loop configuration
  output sicd_pkg::sicd_gain_t       gain [8],
  output sicd_pkg::sicd_gain_t       accel_fb_gain_b_eff,
  input  wire  logic                 standard_velocity_filter,
  output logic                       dir_reverse,
  input  wire  logic                 move_negative,
  output logic                       rotate_ccw,
  input  wire  logic                 closed_loop_active,
  output logic                       seq_fault,
  // encoders and dual loop
  output logic                       dual_loop,
  input  wire  logic [31:0]          pri_pos,
  input  wire  logic [31:0]          sec_pos,
  output logic [31:0]                err_check_pos,
  output logic [31:0]                target_pos,
  output logic                       target_load,
  // idle indication
  input  wire  logic                 cmds_pending,
  input  wire  logic                 motion_active,
  input  wire  logic                 err_in_limits,
  output logic                       idle_line,
  // digital inputs
  input  wire  logic [LINES-1:0]     din_raw,
  output logic [LINES-1:0]           din_filt
);
  import sicd_pkg::*;

  // reset release through two flops
  logic rst_s1_reg, rst_n;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // total words of a command, from its opcode
  function automatic logic [3:0] cmd_len(input logic [7:0] op);
    if (op == `SICD_OP_GAIN)        cmd_len = `SICD_LEN_GAIN;
    else if (op == `SICD_OP_FILTER) cmd_len = `SICD_LEN_FILTER;
    else if (op == `SICD_OP_DIR)    cmd_len = `SICD_LEN_DIR;
    else                            cmd_len = 4'h1;
  endfunction

  function automatic logic known_op(input logic [7:0] op);
    known_op = (op == `SICD_OP_GAIN) || (op == `SICD_OP_FILTER) ||
               (op == `SICD_OP_DIR) || (op == `SICD_OP_DUAL) ||
               (op == `SICD_OP_IDLE_OFF) || (op == `SICD_OP_IDLE_HI) ||
               (op == `SICD_OP_IDLE_LO);
  endfunction

  // command word collector
  sicd_state_e  state_reg;
  logic [7:0]   op_reg;
  logic [3:0]   left_reg;
  logic [3:0]   idx_reg;
  logic [15:0]  arg_reg [8];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SICD_OPCODE;
      op_reg    <= 8'h00;
      left_reg  <= 4'h0;
      idx_reg   <= 4'h0;
    end else if (cw_valid) begin
      case (state_reg)
        SICD_OPCODE: begin
          op_reg   <= cw_data[7:0];
          left_reg <= cmd_len(cw_data[7:0]) - 4'h1;
          idx_reg  <= 4'h0;
          if (cmd_len(cw_data[7:0]) != 4'h1) state_reg <= SICD_ARGS;
        end
        SICD_ARGS: begin
          idx_reg  <= idx_reg + 4'h1;
          left_reg <= left_reg - 4'h1;
          if (left_reg == 4'h1) state_reg <= SICD_OPCODE;
        end
        default: state_reg <= SICD_OPCODE;
      endcase
    end
  end

  // argument capture
  always_ff @(posedge sys_clk) begin
    if (cw_valid && state_reg == SICD_ARGS) arg_reg[idx_reg[2:0]] <= cw_data;
  end

  // command completes on its last word
  logic        exec;
  logic [7:0]  exec_op;
  logic [15:0] last_w;
  assign exec = cw_valid && ((state_reg == SICD_OPCODE &&
                cmd_len(cw_data[7:0]) == 4'h1) ||
                (state_reg == SICD_ARGS && left_reg == 4'h1));
  assign exec_op = (state_reg == SICD_OPCODE) ? cw_data[7:0] : op_reg;
  assign last_w  = cw_data;

  // acknowledge only, no data returned
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cmd_ack <= 1'b0;
    else        cmd_ack <= exec && known_op(exec_op);
  end

  // gain set, word order fixed by the command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) gain[i] <= 15'h0000;
    end else if (exec && exec_op == `SICD_OP_GAIN) begin
      for (int i = 0; i < 7; i++) gain[i] <= arg_reg[i][14:0];
      gain[7] <= last_w[14:0];
    end
  end
  // accel fb b dropped under the standard velocity filter
  assign accel_fb_gain_b_eff = standard_velocity_filter ? 15'h0000 :
                               gain[4];

  // idle indication enable and polarity
  logic idle_en_reg, idle_low_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_en_reg  <= 1'b0;
      idle_low_reg <= 1'b0;
    end else if (exec) begin
      if (exec_op == `SICD_OP_IDLE_OFF) idle_en_reg <= 1'b0;
      else if (exec_op == `SICD_OP_IDLE_HI) begin
        idle_en_reg  <= 1'b1;
        idle_low_reg <= 1'b0;
      end else if (exec_op == `SICD_OP_IDLE_LO) begin
        idle_en_reg  <= 1'b1;
        idle_low_reg <= 1'b1;
      end
    end
  end
  // line 1 drive: low when disabled
  logic idle_cond;
  assign idle_cond = !cmds_pending && !motion_active && err_in_limits;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) idle_line <= 1'b0;
    else idle_line <= idle_en_reg && (idle_cond ^ idle_low_reg);
  end

  // direction and sequence fault
  logic seq_ev;
  assign seq_ev = exec && exec_op == `SICD_OP_DIR && closed_loop_active;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reverse <= 1'b0;
      seq_fault   <= 1'b0;
    end else if (exec && exec_op == `SICD_OP_DIR) begin
      if (closed_loop_active) seq_fault <= 1'b1;
      else dir_reverse <= last_w[0];
    end
  end
  assign rotate_ccw = move_negative ^ dir_reverse;

  // dual loop entry and target copy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dual_loop   <= 1'b0;
      target_load <= 1'b0;
      target_pos  <= 32'h0000_0000;
    end else begin
      target_load <= 1'b0;
      if (exec && exec_op == `SICD_OP_DUAL) begin
        dual_loop   <= 1'b1;
        target_load <= 1'b1;
        target_pos  <= sec_pos;
      end
    end
  end
  assign err_check_pos = dual_loop ? sec_pos : pri_pos;

  // tick generator for the input filter
  logic [$clog2(TICK_CYC)-1:0] tdiv_reg;
  logic tick;
  assign tick = (tdiv_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)    tdiv_reg <= '0;
    else if (tick) tdiv_reg <= '0;
    else           tdiv_reg <= tdiv_reg + 1'b1;
  end

  // per-line filter constants and up/down counters
  logic [14:0] fconst_reg [LINES];
  logic [15:0] fcnt_reg   [LINES];
  logic [LINES-1:0] chg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LINES; i++) fconst_reg[i] <= `SICD_FILT_RST;
    end else if (exec && exec_op == `SICD_OP_FILTER) begin
      for (int i = 0; i < LINES; i++)
        if (arg_reg[0] == 16'h0000 || arg_reg[0] == 16'(i + 1))
          fconst_reg[i] <= last_w[14:0];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_filt <= '0;
      for (int i = 0; i < LINES; i++) fcnt_reg[i] <= 16'h0000;
    end else if (tick) begin
      for (int i = 0; i < LINES; i++) begin
        if (din_raw[i] != din_filt[i]) begin
          if (fcnt_reg[i] + 16'h0001 >= {1'b0, fconst_reg[i]}) begin
            din_filt[i] <= din_raw[i];
            fcnt_reg[i] <= 16'h0000;
          end else fcnt_reg[i] <= fcnt_reg[i] + 16'h0001;
        end else if (fcnt_reg[i] != 16'h0000)
          fcnt_reg[i] <= fcnt_reg[i] - 16'h0001;
      end
    end
  end
  always_comb begin
    chg = '0;
    for (int i = 0; i < LINES; i++)
      chg[i] = tick && din_raw[i] != din_filt[i] &&
               fcnt_reg[i] + 16'h0001 >= {1'b0, fconst_reg[i]};
  end

  // sticky status, set wins over write-one clear
  sicd_evt_t status_reg, mask_reg, ev;
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  assign ev[`SICD_EV_ACK]   = exec && known_op(exec_op);
  assign ev[`SICD_EV_SEQ]   = seq_ev;
  assign ev[`SICD_EV_INCHG] = |chg;
  assign ev[`SICD_EV_BADOP] = exec && !known_op(exec_op);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
      mask_reg   <= '0;
    end else begin
      if (wr_acc && paddr == `SICD_A_STATUS)
        status_reg <= (status_reg & ~pwdata[3:0]) | ev;
      else
        status_reg <= status_reg | ev;
      if (wr_acc && paddr == `SICD_A_MASK) mask_reg <= pwdata[3:0];
    end
  end
  assign irq = |(status_reg & mask_reg);

  // apb read mux, sampled in the setup phase
  logic        hit;
  logic [31:0] rd;
  always_comb begin
    hit = 1'b1;
    rd  = 32'h0000_0000;
    if (paddr == `SICD_A_STATUS) rd = {28'h0, status_reg};
    else if (paddr == `SICD_A_MASK) rd = {28'h0, mask_reg};
    else if (paddr == `SICD_A_MODE)
      rd = {27'h0, seq_fault, dual_loop, dir_reverse, idle_low_reg,
            idle_en_reg};
    else if (paddr == `SICD_A_INPUTS) rd = 32'(din_filt);
    else if (paddr[11:5] == 7'(`SICD_A_GAIN0 >> 5) && paddr[1:0] == 2'b00)
      rd = {17'h0, gain[paddr[4:2]]};
    else if (paddr[11:5] == 7'(`SICD_A_FILT0 >> 5) && paddr[1:0] == 2'b00
             && paddr[4:2] < 3'(LINES))
      rd = {17'h0, fconst_reg[paddr[4:2]]};
    else hit = 1'b0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd;
      pslverr <= !hit;
    end
  end
  assign pready = 1'b1;

  // checks
  ack_one_cycle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(cw_valid) |-> !cmd_ack) else $error("ack stuck");
  gain_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec && exec_op == `SICD_OP_GAIN |=> gain[7] == $past(last_w[14:0])
    && gain[0] == $past(arg_reg[0][14:0])) else $error("gain load");
  gain_b_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    standard_velocity_filter |-> accel_fb_gain_b_eff == 15'h0000)
    else $error("accel b not dropped");
  idle_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec && exec_op == `SICD_OP_IDLE_OFF |=> ##1 !idle_line)
    else $error("idle not off");
  idle_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    idle_en_reg && !idle_low_reg && !idle_cond |=> !idle_line)
    else $error("idle while busy");
  filt_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec && exec_op == `SICD_OP_FILTER && arg_reg[0] == 16'h0001 |=>
    fconst_reg[0] == $past(last_w[14:0])) else $error("filter sel");
  filt_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !tick |=> $stable(din_filt)) else $error("filter off tick");
  filt_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && fconst_reg[0] == 15'h0000 && din_raw[0] != din_filt[0] |=>
    din_filt[0] == $past(din_raw[0])) else $error("zero pass");
  dir_fault_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_ev |=> seq_fault && $stable(dir_reverse))
    else $error("dir after loop");
  dir_sense_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rotate_ccw == (move_negative != dir_reverse))
    else $error("sense");
  dual_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec && exec_op == `SICD_OP_DUAL |=> target_load && dual_loop &&
    target_pos == $past(sec_pos)) else $error("dual entry");
  err_pos_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dual_loop |-> err_check_pos == sec_pos) else $error("err pos");
  cov_gain_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    exec && exec_op == `SICD_OP_GAIN);
  cov_fault_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    seq_ev);
  cov_filt_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    |chg);
  cov_irq_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    irq);
endmodule

/* testbench/sicd_host_model.sv */
// host model: sends command frames on the word channel
// assumes each frame starts just after a rising sys_clk edge
`timescale 1ns/1ps
module sicd_host_model (
  // clock
  input  wire logic        sys_clk,
  // command word channel
  output logic             cw_valid,
  output logic [15:0]      cw_data
);
  // idle channel at time zero
  initial begin
    cw_valid = 1'b0;
    cw_data  = 16'h0000;
  end
  // one frame, words back to back, only what the caller asks for
  task automatic send(input logic [15:0] w [$]);
    foreach (w[i]) begin
      cw_valid <= 1'b1;
      cw_data  <= w[i];
      @(posedge sys_clk);
    end
    // released lines must not look like a stale word
    cw_valid <= 1'b0;
    cw_data  <= ~w[w.size()-1];
  endtask
endmodule

/* testbench/servo_init_command_decoder_tb_top.sv */
// self-checking bench for the command decoder
// assumes sicd_top with a short tick and the host model
`timescale 1ns/1ps
`include "sicd_defines.svh"
module servo_init_command_decoder_tb_top;
  import sicd_pkg::*;
  localparam int TICK = 10;
  logic        sys_clk = 1'b0, arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, err_check_pos, target_pos;
  logic [31:0] pri_pos = 32'h0badf00d, sec_pos = 32'h12345678;
  logic        pready, pslverr, irq, cw_valid, cmd_ack, perr;
  logic [15:0] cw_data;
  sicd_gain_t  gain [8];
  sicd_gain_t  accel_fb_gain_b_eff;
  logic        standard_velocity_filter = 1'b0, move_negative = 1'b0;
  logic        closed_loop_active = 1'b0, cmds_pending = 1'b0;
  logic        motion_active = 1'b0, err_in_limits = 1'b1;
  logic        dir_reverse, rotate_ccw, seq_fault, dual_loop;
  logic        target_load, idle_line;
  logic [6:0]  din_raw = 7'h00, din_filt;
  int          fail_count = 0, n_checks = 0, cyc = 0;

  // design under test with a short tick
  sicd_top #(.LINES(7), .TICK_CYC(TICK)) uut (
    .sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .irq, .cw_valid, .cw_data, .cmd_ack,
    .gain, .accel_fb_gain_b_eff, .standard_velocity_filter,
    .dir_reverse, .move_negative, .rotate_ccw, .closed_loop_active,
    .seq_fault, .dual_loop, .pri_pos, .sec_pos, .err_check_pos,
    .target_pos, .target_load, .cmds_pending, .motion_active,
    .err_in_limits, .idle_line, .din_raw, .din_filt);
  // far side of the command channel
  sicd_host_model host (.sys_clk, .cw_valid, .cw_data);

  // 50 MHz clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    chk("pready", 1, pready);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic hold(input logic [6:0] v, input int n);
    din_raw <= v;
    repeat (n * TICK) @(posedge sys_clk);
  endtask

  task automatic t_reset;
    chk("dir_reverse", 0, dir_reverse);
    chk("idle_line", 0, idle_line);
    for (int i = 0; i < 7; i++) rchk("fconst", 12'h040 + 12'(4*i), 83);
    $display("test reset done");
  endtask
  task automatic t_gain;
    logic [15:0] w [$];
    w = '{16'h0046, 16'h0001, 16'h0202, 16'h7fff, 16'h0404,
          16'h0505, 16'h0606, 16'h8007, 16'h1000};
    host.send(w);
    #1;
    chk("cmd_ack", 1, cmd_ack);
    for (int i = 0; i < 8; i++) chk("gain", w[i+1][14:0], gain[i]);
    chk("afb_b_eff", 15'h0505, accel_fb_gain_b_eff);
    @(posedge sys_clk);
    standard_velocity_filter <= 1'b1;
    #1;
    chk("afb_b_eff std", 0, accel_fb_gain_b_eff);
    chk("cmd_ack end", 0, cmd_ack);
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
      rchk("gain reg", 12'h020 + 12'(4*i), w[i+1][14:0]);
    $display("test gain done");
  endtask
  task automatic t_idle;
    logic [2:0] c [4];
    c = '{3'b001, 3'b101, 3'b011, 3'b000};
    for (int p = 0; p < 2; p++) begin
      host.send('{p ? 16'h00bb : 16'h00fb});
      for (int k = 0; k < 4; k++) begin
        {cmds_pending, motion_active, err_in_limits} <= c[k];
        repeat (3) @(posedge sys_clk);
        chk("idle_line", (c[k] == 3'b001) ^ p[0], idle_line);
      end
    end
    host.send('{16'h00ab});
    repeat (2) @(posedge sys_clk);
    chk("idle off", 0, idle_line);
    $display("test idle done");
  endtask
  task automatic t_filter;
    host.send('{16'h00fc, 16'h0003, 16'h0005});
    #1;
    chk("cmd_ack", 1, cmd_ack);
    @(posedge sys_clk);
    rchk("fconst 3", 12'h048, 5);
    rchk("fconst 2", 12'h044, 83);
    host.send('{16'h00fc, 16'h0000, 16'h0008});
    for (int i = 0; i < 7; i++) rchk("fconst", 12'h040 + 12'(4*i), 8);
    wr(`SICD_A_MASK, 32'h4);
    // bounce: one tick short of the constant
    hold(7'h7f, 5);
    hold(7'h00, 2);
    hold(7'h7f, 4);
    chk("din_filt early", 0, din_filt);
    hold(7'h7f, 2);
    chk("din_filt", 7'h7f, din_filt);
    chk("irq", 1, irq);
    wr(`SICD_A_STATUS, 32'h4);
    chk("irq clear", 0, irq);
    host.send('{16'h00fc, 16'h0000, 16'h0000});
    hold(7'h00, 2);
    chk("din_filt zero", 0, din_filt);
    $display("test filter done");
  endtask
  task automatic t_dir;
    for (int d = 1; d >= 0; d--) begin
      host.send('{16'h00b8, 16'(d)});
      #1;
      chk("dir_reverse", d, dir_reverse);
      for (int m = 0; m < 2; m++) begin
        @(posedge sys_clk);
        move_negative <= m[0];
        #1;
        chk("rotate_ccw", m ^ d, rotate_ccw);
      end
      @(posedge sys_clk);
    end
    wr(`SICD_A_MASK, 32'h2);
    chk("irq masked", 0, irq);
    closed_loop_active <= 1'b1;
    host.send('{16'h00b8, 16'h0001});
    #1;
    chk("cmd_ack", 1, cmd_ack);
    chk("dir kept", 0, dir_reverse);
    chk("seq_fault", 1, seq_fault);
    chk("irq", 1, irq);
    @(posedge sys_clk);
    wr(`SICD_A_STATUS, 32'h2);
    chk("irq clear", 0, irq);
    $display("test dir done");
  endtask
  task automatic t_dual;
    chk("err pos", 32'h0badf00d, err_check_pos);
    host.send('{16'h00f3});
    #1;
    chk("cmd_ack", 1, cmd_ack);
    chk("dual_loop", 1, dual_loop);
    chk("target_load", 1, target_load);
    chk("target_pos", 32'h12345678, target_pos);
    chk("err pos", 32'h12345678, err_check_pos);
    repeat (2) @(posedge sys_clk);
    chk("target_load end", 0, target_load);
    $display("test dual done");
  endtask
  task automatic t_refuse;
    rchk("unmapped", 12'h100, 0);
    chk("pslverr", 1, perr);
    host.send('{16'h0055});
    #1;
    chk("unknown ack", 0, cmd_ack);
    $display("test refuse done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset;
    t_gain;
    t_idle;
    t_filter;
    t_dir;
    t_dual;
    t_refuse;
    print_verdict;
  end
endmodule
